// ===== scss_top.sv
// system clock source selector: oscillator control register and switch sequencer
// assumes axi4-lite on core_clk; config bits stable from reset; oscillators report ready
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scss_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  initial_osc_code,
    input  wire logic [1:0]  switch_monitor_config,
    input  wire logic        pin_map_one_way,
    input  wire logic        osc_out_pin_function,
    input  wire logic [4:0]  osc_ready,
    input  wire logic        pll_locked,
    input  wire logic        clock_fail_detect,
    input  wire logic        sleep_mode,
    output logic [4:0]       sys_src_sel,
    output logic             pll_enable,
    output logic             primary_osc_enable,
    output logic             secondary_osc_enable,
    output logic             instr_clk_en,
    output logic             osc_out_instr_clk,
    output logic             fail_safe_monitor,
    output logic             pin_map_freeze
);
    import scss_pkg::*;

    typedef struct packed {
        logic        loaded;
        logic [2:0]  cur;
        logic [2:0]  nxt;
        logic        freeze;
        logic        pinmap;
        logic        fail;
        logic        psleep;
        logic        sec_en;
        logic        swen;
        logic [2:0]  div_src;
        scss_sw_e    sw;
        scss_key_e   key;
        logic [3:0]  key_cnt;
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [15:0] w_data;
        logic [1:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        instr_div;
        logic        instr_en;
        logic [4:0]  sel;
    } scss_state_s;

    scss_state_s st;
    scss_state_s next_st;

    logic [4:0] new_onehot;
    logic       new_ready;
    logic [4:0] cur_onehot;
    logic       switch_allowed;
    logic       monitor_on;
    logic       lock_bit;
    logic [15:0] osc_word;
    logic [15:0] div_word;

    scss_src_mux u_new_mux (
        .code       (st.nxt),
        .div_src    (st.div_src),
        .osc_ready  (osc_ready),
        .src_onehot (new_onehot),
        .src_ready  (new_ready)
    );

    scss_src_mux u_cur_mux (
        .code       (st.cur),
        .div_src    (st.div_src),
        .osc_ready  (osc_ready),
        .src_onehot (cur_onehot),
        .src_ready  ()
    );

    assign switch_allowed = ~switch_monitor_config[1]; // see R7
    assign monitor_on     = (switch_monitor_config == 2'b00); // see R8
    // lock reads 0 mid-switch or in a mode without the pll
    assign lock_bit = pll_locked & scss_uses_pll(st.cur) & (st.sw == SCSS_SW_IDLE); // see R16 see R17

    always_comb begin
        osc_word = 16'h0000;
        osc_word[CUR_LSB +: 3] = st.cur; // see R11
        osc_word[NEW_LSB +: 3] = st.nxt; // see R12
        osc_word[FREEZE_BIT]   = st.freeze;
        osc_word[PINMAP_BIT]   = st.pinmap;
        osc_word[LOCK_BIT]     = lock_bit;
        osc_word[FAIL_BIT]     = st.fail;
        osc_word[PSLEEP_BIT]   = st.psleep;
        osc_word[SEC_EN_BIT]   = st.sec_en;
        osc_word[SWEN_BIT]     = st.swen;
        div_word = 16'h0000;
        div_word[DIVSRC_LSB +: 3] = st.div_src;
    end

    always_comb begin
        logic        do_write;
        logic [3:0]  wsel;
        logic [3:0]  rsel;
        logic        open;
        logic        sel_frozen;
        logic [15:0] wd;
        wd = 16'h0000;
        do_write = 1'b0;
        wsel = 4'h0;
        rsel = 4'h0;
        open = 1'b0;
        sel_frozen = 1'b0;
        next_st = st;
        open = (st.key == SCSS_KEY_OPEN);
        sel_frozen = monitor_on & st.freeze; // see R14

        // the initial oscillator code strap is caught on the first clock after reset release; the other straps are used live
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.cur    = initial_osc_code; // see R5 see R13
            next_st.nxt    = initial_osc_code; // see R13
        end

        // unlock window closes after a few cycles or any other write
        if (st.key != SCSS_KEY_NONE) begin
            if (st.key_cnt == 4'h0) begin
                next_st.key = SCSS_KEY_NONE;
            end else begin
                next_st.key_cnt = st.key_cnt - 4'h1;
            end
        end

        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata[15:0];
            next_st.w_strb = s_axi_wstrb[1:0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        do_write = st.aw_got && st.w_got && !st.bvalid;
        wsel = scss_axi_sel(st.aw_addr);
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = (wsel == 4'h0) ? 2'b10 : 2'b00;
            wd = st.w_data;
            if (wsel != 4'h2 && st.key == SCSS_KEY_OPEN) begin
                next_st.key = SCSS_KEY_NONE;
            end
            if (wsel == 4'h2) begin
                if (wd == UNLOCK_KEY_A && st.w_strb == 2'b11) begin // see R23
                    next_st.key     = SCSS_KEY_A;
                    next_st.key_cnt = 4'(UNLOCK_WINDOW_CYC);
                end else if (wd == UNLOCK_KEY_B && st.key == SCSS_KEY_A && st.w_strb == 2'b11) begin
                    next_st.key     = SCSS_KEY_OPEN;
                    next_st.key_cnt = 4'(UNLOCK_WINDOW_CYC);
                end else begin
                    next_st.key = SCSS_KEY_NONE;
                end
            end else if (wsel == 4'h1) begin
                if (st.w_strb[0]) begin
                    next_st.psleep = wd[PSLEEP_BIT]; // see R19
                    next_st.sec_en = wd[SEC_EN_BIT]; // see R20
                    if (!wd[FAIL_BIT]) begin
                        next_st.fail = 1'b0; // see R18
                    end
                    if (monitor_on && wd[FREEZE_BIT]) begin
                        next_st.freeze = 1'b1;
                    end
                    if (open) begin // see R15
                        if (wd[PINMAP_BIT] || !(pin_map_one_way && st.pinmap)) begin
                            next_st.pinmap = wd[PINMAP_BIT];
                        end
                    end
                    // switch start needs unlock, permission and unfrozen selection
                    if (open && wd[SWEN_BIT] && switch_allowed && !sel_frozen &&
                        st.sw == SCSS_SW_IDLE) begin // see R10 see R21
                        next_st.swen = 1'b1;
                        next_st.sw   = SCSS_SW_WAIT;
                    end
                end
                if (st.w_strb[1] && open && !sel_frozen && st.sw == SCSS_SW_IDLE) begin
                    next_st.nxt = wd[NEW_LSB +: 3]; // see R10 see R12
                end
            end else if (wsel == 4'h4) begin
                if (st.w_strb[1]) begin
                    next_st.div_src = wd[DIVSRC_LSB +: 3]; // see R9
                end
            end
        end

        // set wins over the software clear
        if (monitor_on && clock_fail_detect) begin
            next_st.fail = 1'b1; // see R18
        end

        case (st.sw) // see R22
            SCSS_SW_IDLE: begin
                next_st.sw = next_st.sw;
            end
            SCSS_SW_WAIT: begin
                if (new_ready) begin
                    next_st.sw = SCSS_SW_CHANGE;
                end
            end
            SCSS_SW_CHANGE: begin
                next_st.cur  = st.nxt;
                next_st.swen = 1'b0; // see R21
                next_st.sw   = SCSS_SW_IDLE;
            end
            default: begin
                next_st.sw = SCSS_SW_IDLE;
            end
        endcase

        // source select is zero while the sequencer waits, otherwise the one-hot of the current source, registered one cycle late
        next_st.sel = (st.sw == SCSS_SW_WAIT) ? 5'h00 : cur_onehot; // see R1

        next_st.instr_div = ~st.instr_div; // see R4
        next_st.instr_en  = st.instr_div;

        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rsel = scss_axi_sel(s_axi_araddr);
            next_st.rvalid = 1'b1;
            next_st.rresp  = (rsel == 4'h0) ? 2'b10 : 2'b00;
            case (rsel)
                4'h1:    next_st.rdata = {16'h0000, osc_word};
                4'h4:    next_st.rdata = {16'h0000, div_word};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end else begin
            rsel = 4'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.div_src <= DIVSRC_RESET; // see R9
            st.sw      <= SCSS_SW_IDLE;
            st.key     <= SCSS_KEY_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = ~st.aw_got & ~st.bvalid;
    assign s_axi_wready  = ~st.w_got & ~st.bvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = ~st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    assign sys_src_sel          = st.sel;
    // pll runs for either pll mode; fast rc nominal 8 mhz feeds it in that mode
    assign pll_enable           = scss_uses_pll(st.cur) | scss_uses_pll(st.nxt) & (st.sw != SCSS_SW_IDLE); // see R2 see R3
    assign primary_osc_enable   = ~sleep_mode | st.psleep; // see R19
    assign secondary_osc_enable = st.sec_en; // see R20
    assign instr_clk_en         = st.instr_en; // see R4
    assign osc_out_instr_clk    = osc_out_pin_function & st.instr_en &
                                  (st.cur == SRC_PRIMARY || st.cur == SRC_PRIMARY_PLL); // see R4
    assign fail_safe_monitor    = monitor_on; // see R8
    assign pin_map_freeze       = st.pinmap;
endmodule

// ===== scss_pkg.sv
// constants, offsets and types of the system clock source selector
// assumes an axi4-lite master on the same core_clk, oscillator status as synchronous inputs
//
// Behaviour
// R1: system clock comes from one of five oscillator sources.
// R2: primary and fast rc may feed the pll; 96 mhz postscaled or 4x/6x/8x.
// R3: fast rc oscillator is nominally 8 mhz.
// R4: instruction clock is the processor clock divided by two, optionally on pin.
// R5: power-on source comes from configuration bits; unprogrammed gives divided mode.
// R6: initial oscillator code decodes 111 divided down to 000 fast rc.
// R7: software switching only when switch/monitor config upper bit is zero.
// R8: fail-safe monitor active only when both config bits are zero.
// R9: divided mode input is chosen by a 3-bit field, fast rc at reset.
// R10: oscillator control register writes are guarded by a write lock; the code locks only bits 10-8, 6 and 0, the other bits write without unlock.
// R11: bits 14-12 read the oscillator currently in use.
// R12: bits 10-8 hold the requested new oscillator.
// R13: current and new fields load from the initial code at reset.
// R14: with monitor enabled, freeze bit 7 locks clock selections.
// R15: pin map freeze changes only after unlock; one-way keeps it set.
// R16: pll lock bit 5 reads 1 when locked or start-up timer expired.
// R17: pll lock bit forced to 0 during a switch or non-pll mode.
// R18: clock fail flag set by monitor, software may only clear it.
// R19: primary sleep enable bit 2 keeps primary running in sleep.
// R20: secondary enable bit 1 turns the 32 khz oscillator on or off.
// R21: writing 1 to bit 0 starts a switch; hardware clears it when done.
// R22: switch waits for stable new source, then copies new into current.
// R23: software writes the unlock key pair just before the control write.
package scss_pkg;
    localparam logic [2:0] SRC_FAST_RC       = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL   = 3'h1;
    localparam logic [2:0] SRC_PRIMARY       = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL   = 3'h3;
    localparam logic [2:0] SRC_SECONDARY     = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC  = 3'h5;
    localparam logic [2:0] SRC_DIGITAL_TUNED = 3'h6;
    localparam logic [2:0] SRC_DIVIDED       = 3'h7;

    localparam logic [11:0] ADDR_OSC_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_UNLOCK      = 12'h004;
    localparam logic [11:0] ADDR_CLK_DIVIDER = 12'h008;

    localparam logic [15:0] UNLOCK_KEY_A = 16'h55aa;
    localparam logic [15:0] UNLOCK_KEY_B = 16'haa55;

    localparam int CUR_LSB    = 12;
    localparam int NEW_LSB    = 8;
    localparam int FREEZE_BIT = 7;
    localparam int PINMAP_BIT = 6;
    localparam int LOCK_BIT   = 5;
    localparam int FAIL_BIT   = 3;
    localparam int PSLEEP_BIT = 2;
    localparam int SEC_EN_BIT = 1;
    localparam int SWEN_BIT   = 0;
    localparam int DIVSRC_LSB = 8;

    localparam logic [2:0] DIVSRC_RESET = 3'h0;

    localparam int CLK_MHZ          = 100;
    localparam int UNLOCK_WINDOW_NS = 100;
    localparam int UNLOCK_WINDOW_CYC = (UNLOCK_WINDOW_NS * CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        SCSS_SW_IDLE   = 2'b00,
        SCSS_SW_WAIT   = 2'b01,
        SCSS_SW_CHANGE = 2'b10
    } scss_sw_e;

    typedef enum logic [1:0] {
        SCSS_KEY_NONE = 2'b00,
        SCSS_KEY_A    = 2'b01,
        SCSS_KEY_OPEN = 2'b10
    } scss_key_e;

    function automatic logic scss_uses_pll(input logic [2:0] code);
        return (code == SRC_FAST_RC_PLL) || (code == SRC_PRIMARY_PLL);
    endfunction

    function automatic logic [3:0] scss_axi_sel(input logic [11:0] addr);
        scss_axi_sel = 4'h0;
        if (addr == ADDR_OSC_CONTROL) scss_axi_sel = 4'h1;
        if (addr == ADDR_UNLOCK) scss_axi_sel = 4'h2;
        if (addr == ADDR_CLK_DIVIDER) scss_axi_sel = 4'h4;
    endfunction
endpackage

// ===== scss_src_mux.sv
// one-hot source decode and ready lookup for a source code
// assumes the ready inputs are already synchronous to core_clk
`timescale 1ns/1ps
module scss_src_mux (
    input  wire logic [2:0] code,
    input  wire logic [2:0] div_src,
    input  wire logic [4:0] osc_ready,
    output logic      [4:0] src_onehot,
    output logic            src_ready
);
    import scss_pkg::*;
    logic [2:0] eff;

    always_comb begin
        eff = (code == SRC_DIVIDED) ? div_src : code;
        src_onehot = 5'h00;
        case (eff) // see R1 see R6
            SRC_FAST_RC, SRC_FAST_RC_PLL: src_onehot = 5'h01;
            SRC_PRIMARY, SRC_PRIMARY_PLL: src_onehot = 5'h02;
            SRC_SECONDARY:                src_onehot = 5'h04;
            SRC_LOW_POWER_RC:             src_onehot = 5'h08;
            SRC_DIGITAL_TUNED:            src_onehot = 5'h10;
            default:                      src_onehot = 5'h01;
        endcase
        src_ready = |(src_onehot & osc_ready);
    end
endmodule

// ===== scss_top_checker.sv
// port-level assertions for the clock source selector
// assumes binding onto scss_top; one core_clk domain
`timescale 1ns/1ps
module scss_top_checker
    import scss_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  switch_monitor_config,
    input wire logic        sleep_mode,
    input wire logic        osc_out_pin_function,
    input wire logic [4:0]  sys_src_sel,
    input wire logic        primary_osc_enable,
    input wire logic        instr_clk_en,
    input wire logic        osc_out_instr_clk,
    input wire logic        fail_safe_monitor
);
    logic [11:0] rd_a;
    // last read address, so the lock bit is judged only on control reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a <= 12'h000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_a <= s_axi_araddr;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_monitor_cfg: assert property (fail_safe_monitor == (switch_monitor_config == 2'b00))
        else $error("monitor enable wrong");
    a_primary_awake: assert property (!sleep_mode |-> primary_osc_enable)
        else $error("primary stopped while awake");
    a_instr_half: assert property (instr_clk_en |=> !instr_clk_en ##1 instr_clk_en)
        else $error("instruction clock not half rate");
    a_pin_gate: assert property (osc_out_instr_clk |-> instr_clk_en && osc_out_pin_function)
        else $error("pin clock without cause");
    a_one_source: assert property ($onehot0(sys_src_sel))
        else $error("more than one source selected");
    a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
        else $error("unused read bits set");
    a_lock_pll: assert property (s_axi_rvalid && rd_a == ADDR_OSC_CONTROL && s_axi_rdata[LOCK_BIT]
        |-> scss_uses_pll(s_axi_rdata[14:12])) else $error("lock bit in non-pll mode");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    cover property (osc_out_instr_clk);
    cover property (sys_src_sel == 5'h0 ##1 sys_src_sel != 5'h0);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind scss_top scss_top_checker u_chk (.*);

// ===== scss_osc_model.sv
// oscillator and pll stand-in: ready after a start-up count
// assumes the bench chooses slow start-up and primary failure
`timescale 1ns/1ps
module scss_osc_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       primary_osc_enable,
    input  wire logic       secondary_osc_enable,
    input  wire logic       pll_enable,
    input  wire logic       slow,
    input  wire logic       kill_primary,
    output logic      [4:0] osc_ready,
    output logic            pll_locked,
    output logic            clock_fail_detect
);
    logic [5:0] run;
    logic [3:0] cnt [6];
    logic [3:0] settle;
    assign settle = slow ? 4'hc : 4'h2;
    // fast rc stands for the 8 mhz source; secondary and primary run only when enabled
    assign run = {pll_enable, 2'b11, secondary_osc_enable, primary_osc_enable & ~kill_primary, 1'b1};
    assign clock_fail_detect = kill_primary;
    always_ff @(posedge core_clk or negedge rst_n) begin
        for (int i = 0; i < 6; i++) begin
            if (!rst_n || !run[i]) begin
                cnt[i] <= 4'h0;
            end else if (cnt[i] != 4'hf) begin
                cnt[i] <= cnt[i] + 4'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            osc_ready[i] = cnt[i] >= settle;
        end
    end
    assign pll_locked = cnt[5] >= settle;
endmodule

// ===== test_scss_top.sv
// self-checking bench: axi4-lite master plus oscillator model around scss_top
// assumes scss_pkg offsets and unlock keys; bench is the only bus master
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_scss_top;
    import scss_pkg::*;
    logic        core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_enable;
    logic        pin_map_one_way, osc_out_pin_function, sleep_mode, slow, kill_primary, pll_locked;
    logic        primary_osc_enable, secondary_osc_enable, instr_clk_en, osc_out_instr_clk;
    logic        fail_safe_monitor, pin_map_freeze, clock_fail_detect;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [4:0]  osc_ready, sys_src_sel;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  initial_osc_code;
    logic [1:0]  s_axi_bresp, s_axi_rresp, switch_monitor_config, r;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    scss_top uut (.*);
    scss_osc_model u_osc (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            final_report();
        end
    end
    // handshakes are judged at the falling edge, so the values the design saw at the next rising edge
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        int t;
        logic aw_ok, w_ok, b_ok;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        t = 0;
        do begin
            @(negedge core_clk);
            aw_ok = s_axi_awvalid & s_axi_awready;
            w_ok = s_axi_wvalid & s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            t++;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok && t < 60);
        if (!b_ok) n_errors++;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a);
        int t;
        logic ar_ok, r_ok;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 0;
        do begin
            @(negedge core_clk);
            ar_ok = s_axi_arvalid & s_axi_arready;
            r_ok = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            t++;
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok && t < 60);
        if (!r_ok) n_errors++;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    // the control write must follow the key pair closely or the window shuts
    task automatic uwr(input logic [15:0] d);
        wr(ADDR_UNLOCK, UNLOCK_KEY_A);
        wr(ADDR_UNLOCK, UNLOCK_KEY_B);
        wr(ADDR_OSC_CONTROL, d);
    endtask
    task automatic wait_sw();
        int k;
        k = 0;
        do begin
            rd(ADDR_OSC_CONTROL);
            k++;
        end while (v[SWEN_BIT] !== 1'b0 && k < 40);
    endtask
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'h3;
        initial_osc_code = SRC_DIVIDED;
        switch_monitor_config = 2'b01;
        {pin_map_one_way, osc_out_pin_function, sleep_mode, slow, kill_primary} = 5'b11000;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(ADDR_OSC_CONTROL);
        `CHK(v, 32'h0000_7700)
        rd(ADDR_CLK_DIVIDER);
        `CHK(v[10:8], DIVSRC_RESET)
        `CHK(fail_safe_monitor, 1'b0)
        wr(ADDR_OSC_CONTROL, 16'h0301);
        rd(ADDR_OSC_CONTROL);
        `CHK(v[14:8], 7'h77)
        slow <= 1'b1;
        uwr(16'h0307);
        wait_sw();
        `CHK(v[14:12], SRC_PRIMARY_PLL)
        `CHK(secondary_osc_enable, 1'b1)
        `CHK(sys_src_sel, 5'h02)
        `CHK(pll_enable, 1'b1)
        repeat (16) @(posedge core_clk);
        rd(ADDR_OSC_CONTROL);
        `CHK(v[LOCK_BIT], 1'b1)
        sleep_mode <= 1'b1;
        uwr(16'h0007);
        wait_sw();
        `CHK(v[14:12], SRC_FAST_RC)
        `CHK(v[LOCK_BIT], 1'b0)
        `CHK(primary_osc_enable, 1'b1)
        uwr(16'h0002);
        `CHK(primary_osc_enable, 1'b0)
        switch_monitor_config <= 2'b10;
        uwr(16'h0503);
        wait_sw();
        `CHK(v[14:12], SRC_FAST_RC)
        switch_monitor_config <= 2'b00;
        uwr(16'h0082);
        `CHK(fail_safe_monitor, 1'b1)
        uwr(16'h0583);
        wait_sw();
        `CHK(v[14:12], SRC_FAST_RC)
        `CHK(v[FREEZE_BIT], 1'b1)
        wr(ADDR_OSC_CONTROL, 16'h008a);
        rd(ADDR_OSC_CONTROL);
        `CHK(v[FAIL_BIT], 1'b0)
        kill_primary <= 1'b1;
        repeat (3) @(posedge core_clk);
        kill_primary <= 1'b0;
        rd(ADDR_OSC_CONTROL);
        `CHK(v[FAIL_BIT], 1'b1)
        wr(ADDR_OSC_CONTROL, 16'h0082);
        rd(ADDR_OSC_CONTROL);
        `CHK(v[FAIL_BIT], 1'b0)
        wr(ADDR_OSC_CONTROL, 16'h00c2);
        `CHK(pin_map_freeze, 1'b0)
        uwr(16'h00c2);
        `CHK(pin_map_freeze, 1'b1)
        uwr(16'h0082);
        `CHK(pin_map_freeze, 1'b1)
        wr(12'h00c, 16'hffff);
        `CHK(r, 2'b10)
        rd(12'h00c);
        `CHK({r, v}, {2'b10, 32'h0})
        final_report();
    end
endmodule
